/* File: core/bph_pkg.sv */
// Purpose: Shared constants and types of the buffered handshake port.
// Assumes: One reference clock; the port clock is derived from it by a divider.
// Notes:   The port works as an input or an output port, never both at once.
//
// Behaviour
// - A handshake configuration whose flow line is wider than one bit raises an exception.
// - In input mode the outgoing flow line rises on a falling edge while the buffer has room.
// - In input mode the pins are captured at the sampling edge only when both flow lines are high.
// - The sampling edge is the rising edge by default and a sample delay can move it later.
// - In output mode the initial value is driven from configuration until a new word goes out.
// - In output mode the incoming flow line is read at the sampling edge.
// - In output mode a pending word is launched only on a falling edge after a high flow sample.
// - In output mode the outgoing flow line is high on a falling edge that launches, else low.
package bph_pkg;

  localparam int          PORT_W_DEF = 8;             // Data pins of the port.
  localparam int          CNT_W      = 16;            // Divider and delay field width.
  localparam int          WIDTH_W    = 8;             // Width code of an assigned flow port.
  localparam logic [7:0]  FLOW_WIDTH = 8'h01;         // The only legal flow port width.
  localparam logic [15:0] HALF_RST   = 16'h0001;      // Half period after reset, in ref cycles.
  localparam logic [15:0] DELAY_RST  = 16'h0000;      // Zero delay means the rising edge.
  localparam int          REF_CLK_NS = 10;            // Reference clock period.

  typedef enum logic [1:0] {
    BPH_OFF,
    BPH_IN,
    BPH_OUT
  } bph_mode_t;

  typedef enum logic {
    BPH_DIR_IN,
    BPH_DIR_OUT
  } bph_dir_t;

endpackage

/* File: core/bph_buf2.sv */
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: Flush has priority over any push or pop in the same cycle.
// Notes:   The head entry is the output, so every output comes from a flop.
`timescale 1ns/1ns
module bph_buf2 #(
  parameter int W = bph_pkg::PORT_W_DEF
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_resetn,
  input  wire logic         i_flush,
  input  wire logic [W-1:0] i_s_data,
  input  wire logic         i_s_valid,
  output logic              o_s_ready,
  output logic [W-1:0]      o_m_data,
  output logic              o_m_valid,
  input  wire logic         i_m_ready
);
  import bph_pkg::*;

  typedef struct packed {
    logic [W-1:0] head;
    logic [W-1:0] tail;
    logic         head_v;
    logic         tail_v;
    logic         rdy;
  } bph_buf_t;

  bph_buf_t r;
  bph_buf_t next_r;
  logic     push;
  logic     pop;

  // Ready is a flop of its own, so it stays low in reset and has no gate after it.
  assign push      = i_s_valid && r.rdy;
  assign pop       = i_m_ready && r.head_v;
  assign o_s_ready = r.rdy;
  assign o_m_data  = r.head;
  assign o_m_valid = r.head_v;

  // The tail moves up on a pop; a push lands in the first free slot after that move.
  always_comb begin
    next_r = r;
    if (pop) begin
      next_r.head   = r.tail;
      next_r.head_v = r.tail_v;
      next_r.tail_v = 1'b0;
    end
    if (push) begin
      if (!next_r.head_v) begin
        next_r.head   = i_s_data;
        next_r.head_v = 1'b1;
      end else begin
        next_r.tail   = i_s_data;
        next_r.tail_v = 1'b1;
      end
    end
    if (i_flush) begin
      next_r.head_v = 1'b0;
      next_r.tail_v = 1'b0;
    end
    next_r.rdy = !next_r.tail_v;
  end

  // State register.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

endmodule

/* File: core/bph_port.sv */
// Purpose: Clocked buffered port in handshake mode, input or output direction.
// Assumes: Peer inputs are synchronous to i_ref_clk; the port clock is driven out by us.
// Notes:   A configuration pulse flushes both buffers and restarts the port clock.
`timescale 1ns/1ns
module bph_port #(
  parameter int W = bph_pkg::PORT_W_DEF
) (
  input  wire logic                    i_ref_clk,
  input  wire logic                    i_resetn,
  // Configuration, sample delay and exception control.
  input  wire logic                    i_cfg_valid,
  input  wire bph_pkg::bph_dir_t       i_cfg_dir,
  input  wire logic [bph_pkg::WIDTH_W-1:0] i_cfg_rdy_in_width,
  input  wire logic [bph_pkg::WIDTH_W-1:0] i_cfg_rdy_out_width,
  input  wire logic [W-1:0]            i_cfg_init,
  input  wire logic [bph_pkg::CNT_W-1:0] i_cfg_half,
  input  wire logic                    i_delay_valid,
  input  wire logic [bph_pkg::CNT_W-1:0] i_delay,
  input  wire logic                    i_exc_clear,
  // Exception flag, port clock, flow lines and data pins toward the peer.
  output logic                         o_exception,
  output logic                         o_port_clk,
  input  wire logic                    i_ready_in,
  output logic                         o_ready_out,
  input  wire logic [W-1:0]            i_pins,
  output logic [W-1:0]                 o_pins,
  output logic                         o_pins_oe,
  // Core-side word streams, each through its own two-entry buffer.
  output logic [W-1:0]                 o_rx_data,
  output logic                         o_rx_valid,
  input  wire logic                    i_rx_ready,
  input  wire logic [W-1:0]            i_tx_data,
  input  wire logic                    i_tx_valid,
  output logic                         o_tx_ready
);
  import bph_pkg::*;

  // All state of the port outside the two buffers in one register: mode, divider, the two flow
  // registers and the driven pins, so every output below is a flop.
  typedef struct packed {
    bph_mode_t        mode;
    logic [CNT_W:0]   cnt;
    logic [CNT_W-1:0] half;
    logic [CNT_W-1:0] dly;
    logic             pclk;
    logic             rdy_out;
    logic             rdy_smp;
    logic [W-1:0]     pins;
    logic             oe;
    logic             exc;
  } bph_state_t;

  // Current state, its next value and the decoded events of this cycle.
  bph_state_t       r;
  bph_state_t       next_r;
  logic [CNT_W:0]   period_m1;
  logic [CNT_W-1:0] smp_at;
  logic             live;
  logic             rise_ev;
  logic             fall_ev;
  logic             smp_ev;
  logic             cfg_bad;
  logic             rx_push;
  logic             rx_room;
  logic             tx_pop;
  logic             tx_valid;
  logic [W-1:0]     tx_head;

  // Port clock phases; events are suppressed in the configuration cycle itself.
  // The divider counts reference cycles, so the port clock is at most half the
  // reference rate, and every port edge lines up with a reference edge.
  assign live      = !i_cfg_valid;
  assign period_m1 = {r.half, 1'b0} - {{CNT_W{1'b0}}, 1'b1};
  // A delay reaching the falling edge is clamped just before it. Sampling and
  // launching in one cycle would let the peer see a flow change under its own
  // sample, which is the hazard the clamp trades a little range against.
  assign smp_at    = (r.dly < r.half) ? r.dly : (r.half - 16'h0001);
  assign rise_ev   = live && (r.cnt == '0);
  assign fall_ev   = live && (r.cnt == {1'b0, r.half});
  assign smp_ev    = live && (r.cnt == {1'b0, smp_at});

  // A flow line of any width other than one bit is illegal.
  // Both widths are checked in either direction, as both lines are used in both.
  assign cfg_bad = (i_cfg_rdy_in_width != FLOW_WIDTH) ||
                   (i_cfg_rdy_out_width != FLOW_WIDTH);

  // Capture needs both flow lines high at the sampling edge.
  // The receive buffer has room here, since room was judged at the last fall.
  assign rx_push = (r.mode == BPH_IN) && smp_ev && i_ready_in && r.rdy_out;

  // Launch needs a pending word and a high flow sample from the last sampling edge.
  // One launch per port period at most, because the fall event occurs once per period.
  assign tx_pop = (r.mode == BPH_OUT) && fall_ev && r.rdy_smp && tx_valid;

  // Receive path: the buffer absorbs a stalled reader for up to two words.
  // Its flush on configuration drops words of an earlier setup.
  bph_buf2 #(
    .W (W)
  ) u_rx_buf (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_flush   (i_cfg_valid),
    .i_s_data  (i_pins),
    .i_s_valid (rx_push),
    .o_s_ready (rx_room),
    .o_m_data  (o_rx_data),
    .o_m_valid (o_rx_valid),
    .i_m_ready (i_rx_ready)
  );

  // Transmit path: words wait here until the peer lets them out.
  // Words are taken in any mode but only leave in output mode.
  bph_buf2 #(
    .W (W)
  ) u_tx_buf (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_flush   (i_cfg_valid),
    .i_s_data  (i_tx_data),
    .i_s_valid (i_tx_valid),
    .o_s_ready (o_tx_ready),
    .o_m_data  (tx_head),
    .o_m_valid (tx_valid),
    .i_m_ready (tx_pop)
  );

  // Next state of the port: divider, configuration, flow lines and pins.
  always_comb begin
    next_r = r;
    // Divider wraps after a full port clock period.
    // The clock flop changes at the two event counts, so its duty cycle is even.
    if (r.cnt == period_m1) begin
      next_r.cnt = '0;
    end else begin
      next_r.cnt = r.cnt + {{CNT_W{1'b0}}, 1'b1};
    end
    // Port clock level follows the events of this cycle.
    if (rise_ev) begin
      next_r.pclk = 1'b1;
    end
    if (fall_ev) begin
      next_r.pclk = 1'b0;
    end
    // The sample delay is a setting of its own and survives reconfiguration.
    if (i_delay_valid) begin
      next_r.dly = i_delay;
    end
    case (r.mode)
      BPH_IN: begin
        // Room is judged at the falling edge; only one capture per period can
        // follow, so the buffer cannot overflow before the next judgement.
        if (fall_ev) begin
          next_r.rdy_out = rx_room;
        end
      end
      BPH_OUT: begin
        // The flow sample is kept until the next sampling point, so a fall that
        // follows a low sample holds the pins even if the peer rises later.
        if (smp_ev) begin
          next_r.rdy_smp = i_ready_in;
        end
        if (fall_ev) begin
          next_r.rdy_out = tx_pop;
        end
        if (tx_pop) begin
          next_r.pins = tx_head;
        end
      end
      default: begin
        // An idle port keeps its flow line low so the peer never sends blind.
        next_r.rdy_out = 1'b0;
      end
    endcase
    // Software clears the sticky exception; a new bad setup in the same cycle wins.
    if (i_exc_clear) begin
      next_r.exc = 1'b0;
    end
    // Configuration restarts the port clock low and clears both flow registers;
    // a half period of zero is taken as one so the divider never stalls.
    if (i_cfg_valid) begin
      next_r.cnt     = '0;
      next_r.pclk    = 1'b0;
      next_r.rdy_out = 1'b0;
      next_r.rdy_smp = 1'b0;
      next_r.half    = (i_cfg_half == '0) ? HALF_RST : i_cfg_half;
      if (cfg_bad) begin
        // A rejected setup leaves the port idle with its pins released.
        next_r.exc  = 1'b1;
        next_r.mode = BPH_OFF;
        next_r.oe   = 1'b0;
      end else if (i_cfg_dir == BPH_DIR_OUT) begin
        next_r.mode = BPH_OUT;
        next_r.pins = i_cfg_init;
        next_r.oe   = 1'b1;
      end else begin
        next_r.mode = BPH_IN;
        next_r.oe   = 1'b0;
      end
    end
  end

  // State register; the reset image leaves the port idle with the default
  // half period and no sample delay.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      r      <= '0;
      r.mode <= BPH_OFF;
      r.half <= HALF_RST;
      r.dly  <= DELAY_RST;
    end else begin
      r <= next_r;
    end
  end

  // Outputs are fields of the state register, so no output has a logic path
  // from an input.
  assign o_exception = r.exc;
  assign o_port_clk  = r.pclk;
  assign o_ready_out = r.rdy_out;
  assign o_pins      = r.pins;
  assign o_pins_oe   = r.oe;

endmodule

/* File: test/bph_port_chk.sv */
// Purpose: Port-level assertions for the buffered handshake port.
// Assumes: One clock domain; only ports of bph_port are seen.
// Notes:   A launch is seen as a change of o_pins, so a repeated word goes unnoticed.
`timescale 1ns/1ns
module bph_port_chk import bph_pkg::*; #(
  parameter int W = PORT_W_DEF
) (
  input wire logic               i_ref_clk,
  input wire logic               i_resetn,
  input wire logic               i_cfg_valid,
  input wire bph_dir_t           i_cfg_dir,
  input wire logic [WIDTH_W-1:0] i_cfg_rdy_in_width,
  input wire logic [WIDTH_W-1:0] i_cfg_rdy_out_width,
  input wire logic [W-1:0]       i_cfg_init,
  input wire logic               i_exc_clear,
  input wire logic               o_exception,
  input wire logic               o_port_clk,
  input wire logic               i_ready_in,
  input wire logic               o_ready_out,
  input wire logic [W-1:0]       o_pins,
  input wire logic               o_pins_oe,
  input wire logic               o_rx_valid
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  logic bad;
  logic seen;
  logic mode_in;
  assign bad = (i_cfg_rdy_in_width != FLOW_WIDTH) || (i_cfg_rdy_out_width != FLOW_WIDTH);
  // Seen notes a high flow level since the last port fall; mode_in notes a good input setup.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      seen    <= 1'b0;
      mode_in <= 1'b0;
    end else begin
      seen    <= i_ready_in || (seen && !$fell(o_port_clk));
      mode_in <= i_cfg_valid ? (!bad && i_cfg_dir == BPH_DIR_IN) : mode_in;
    end
  end
  property p_exc; i_cfg_valid && bad |=> o_exception && !o_pins_oe; endproperty
  a_exc: assert property (p_exc) else $error("bad width not flagged");
  property p_clr; i_exc_clear && !i_cfg_valid |=> !o_exception; endproperty
  a_clr: assert property (p_clr) else $error("exception not cleared");
  property p_init;
    i_cfg_valid && !bad && i_cfg_dir == BPH_DIR_OUT |=> o_pins_oe && o_pins == $past(i_cfg_init);
  endproperty
  a_init: assert property (p_init) else $error("initial value missing");
  property p_hold; o_pins_oe && !i_cfg_valid ##1 $changed(o_pins) |-> $fell(o_port_clk) && o_ready_out; endproperty
  a_hold: assert property (p_hold) else $error("pins moved off a launch");
  property p_seen; o_pins_oe && !i_cfg_valid ##1 $changed(o_pins) |-> seen; endproperty
  a_seen: assert property (p_seen) else $error("launch without flow");
  property p_rdy; !i_cfg_valid ##1 $changed(o_ready_out) |-> $fell(o_port_clk); endproperty
  a_rdy: assert property (p_rdy) else $error("flow moved off a fall");
  property p_rx; $rose(o_rx_valid) |-> $past(i_ready_in && o_ready_out && !o_pins_oe); endproperty
  a_rx: assert property (p_rx) else $error("capture without both flows");
  property p_room; mode_in && !o_rx_valid && !i_cfg_valid ##1 $fell(o_port_clk) |-> o_ready_out; endproperty
  a_room: assert property (p_room) else $error("room but flow low");
endmodule
bind bph_port bph_port_chk #(.W(W)) u_chk (.*);

/* File: test/bph_peer.sv */
// Purpose: Far-side peer driving the flow line and data pins.
// Assumes: The port clock is watched 1 ns after each reference edge.
// Notes:   Values move only just after a port fall, so they stand through sampling.
`timescale 1ns/1ns
module bph_peer #(
  parameter int W = 8
) (
  input  wire logic    i_ref_clk,
  input  wire logic    i_port_clk,
  output logic         o_ready,
  output logic [W-1:0] o_pins
);
  logic [31:0] s = 32'h0000_6f1b;
  logic        q = 1'b0;
  logic        rdy = 1'b0;
  logic [W-1:0] pins = '0;
  assign o_ready = rdy;
  assign o_pins  = pins;
  // New levels after each fall; busy about one period in four, so stalls happen.
  always @(posedge i_ref_clk) begin
    #1;
    if (q && !i_port_clk) begin
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      rdy = s[0] | s[1];
      pins = s[W+1:2];
    end
    q = i_port_clk;
  end
endmodule

/* File: test/tb.sv */
// Purpose: Self-checking bench for the buffered handshake port.
// Assumes: Half period 2 for output; half 3 with delay 0, then delay 1, for input.
// Notes:   Expected words queue where driven; the monitor pops them.
`timescale 1ns/1ns
module tb;
  import bph_pkg::*;
  logic i_ref_clk = 0, i_resetn = 0, i_cfg_valid = 0, i_delay_valid = 0, i_exc_clear = 0;
  bph_dir_t i_cfg_dir = BPH_DIR_IN;
  logic [7:0] i_cfg_rdy_in_width = 0, i_cfg_rdy_out_width = 0, i_cfg_init = 0, i_tx_data = 0;
  logic [15:0] i_cfg_half = 0, i_delay = 0;
  logic i_tx_valid = 0, i_rx_ready = 0, stall = 1, pq = 0, rq = 0;
  logic [7:0] o_pins, o_rx_data, i_pins;
  logic o_exception, o_port_clk, o_ready_out, i_ready_in, o_pins_oe, o_rx_valid, o_tx_ready;
  logic [7:0] txq[$], rxq[$];
  int num_errors = 0, samples_checked = 0;
  int since_rise = 0, exp_dly = 0;
  logic [31:0] s = 32'h0000_6f1b;
  bph_port u_dut (
    .i_ref_clk           (i_ref_clk),
    .i_resetn            (i_resetn),
    .i_cfg_valid         (i_cfg_valid),
    .i_cfg_dir           (i_cfg_dir),
    .i_cfg_rdy_in_width  (i_cfg_rdy_in_width),
    .i_cfg_rdy_out_width (i_cfg_rdy_out_width),
    .i_cfg_init          (i_cfg_init),
    .i_cfg_half          (i_cfg_half),
    .i_delay_valid       (i_delay_valid),
    .i_delay             (i_delay),
    .i_exc_clear         (i_exc_clear),
    .o_exception         (o_exception),
    .o_port_clk          (o_port_clk),
    .i_ready_in          (i_ready_in),
    .o_ready_out         (o_ready_out),
    .i_pins              (i_pins),
    .o_pins              (o_pins),
    .o_pins_oe           (o_pins_oe),
    .o_rx_data           (o_rx_data),
    .o_rx_valid          (o_rx_valid),
    .i_rx_ready          (i_rx_ready),
    .i_tx_data           (i_tx_data),
    .i_tx_valid          (i_tx_valid),
    .o_tx_ready          (o_tx_ready)
  );
  bph_peer u_peer (.i_ref_clk, .i_port_clk(o_port_clk), .o_ready(i_ready_in), .o_pins(i_pins));
  initial forever #5 i_ref_clk = ~i_ref_clk;
  function automatic logic [31:0] rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d, errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic step();
    @(posedge i_ref_clk);
    #1;
  endtask
  task automatic cfg(input bph_dir_t d, input logic [7:0] wi, wo, v, input logic [15:0] h);
    i_cfg_dir = d;
    i_cfg_rdy_in_width = wi;
    i_cfg_rdy_out_width = wo;
    i_cfg_init = v;
    i_cfg_half = h;
    i_cfg_valid = 1;
    step();
    i_cfg_valid = 0;
    rxq.delete();
  endtask
  // Valid stays up between words, so it is never lowered and raised in one step.
  task automatic send(input logic [7:0] d);
    i_tx_data = d;
    i_tx_valid = 1;
    txq.push_back(d);
    while (o_tx_ready !== 1'b1)
      step();
    step();
  endtask
  // Monitor: reader stalls at random, launches and captures are compared in order.
  always @(posedge i_ref_clk) begin
    #1;
    i_rx_ready = !stall && rnd() % 2;
    if (pq && !o_port_clk && o_pins_oe && o_ready_out)
      chk(o_pins, txq.pop_front());
    else if (pq && !o_port_clk && o_pins_oe && txq.size() == 0)
      chk(8'(o_ready_out), 8'h00);
    if (!pq && o_port_clk && i_ready_in && o_ready_out && !o_pins_oe)
      rxq.push_back(i_pins);
    if (o_rx_valid && i_rx_ready)
      chk(o_rx_data, rxq.pop_front());
    // A capture shows as a rise of o_rx_valid exactly delay cycles after the port rise.
    since_rise = (!pq && o_port_clk) ? 0 : since_rise + 1;
    if (!rq && o_rx_valid)
      chk(8'(since_rise), 8'(exp_dly));
    rq = o_rx_valid;
    pq = o_port_clk;
  end
  initial begin
    repeat (20) @(posedge i_ref_clk);
    #1;
    i_resetn = 1;
    cfg(BPH_DIR_OUT, 8'h02, 8'h01, 8'h3c, 16'h0002);
    chk(8'(o_exception), 8'h01);
    i_exc_clear = 1;
    step();
    i_exc_clear = 0;
    chk(8'(o_exception), 8'h00);
    cfg(BPH_DIR_IN, 8'h01, 8'h00, 8'h3c, 16'h0002);
    chk(8'(o_exception), 8'h01);
    chk(8'(o_pins_oe), 8'h00);
    $display("exception test done");
    cfg(BPH_DIR_OUT, 8'h01, 8'h01, 8'ha5, 16'h0002);
    chk(o_pins, 8'ha5);
    chk(8'(o_pins_oe), 8'h01);
    repeat (12) send(8'(rnd()));
    i_tx_valid = 0;
    while (txq.size() != 0)
      step();
    // Idle falls with nothing queued must keep the flow line low.
    repeat (10) step();
    $display("output test done");
    // First at the default delay, so the port rise itself is the sampling point.
    cfg(BPH_DIR_IN, 8'h01, 8'h01, 8'h00, 16'h0003);
    repeat (40) step();
    exp_dly = 1;
    i_delay = 16'h0001;
    i_delay_valid = 1;
    step();
    i_delay_valid = 0;
    cfg(BPH_DIR_IN, 8'h01, 8'h01, 8'h00, 16'h0003);
    repeat (80) step();
    chk(8'(o_ready_out), 8'h00);
    chk(8'(rxq.size()), 8'h02);
    stall = 0;
    repeat (200) step();
    while (rxq.size() != 0)
      step();
    $display("input test done");
    summarize();
  end
  initial begin
    #100000;
    num_errors++;
    summarize();
  end
endmodule
